// >>> src/poc_defs.vh
// poc_defs.vh - offsets, fields, reset values for the offset calibration block
// assumes byte-wide register port; included by bare name
`ifndef POC_DEFS_VH
`define POC_DEFS_VH

`define POC_ADDR_W 8
`define POC_OFS_CFG0 8'hd8
`define POC_OFS_CALIB 8'hd7
`define POC_OFS_STAT 8'hdb
`define POC_OFS_OFFS_BASE 8'hc0
`define POC_CFG0_TRIM_BIT 6
`define POC_CFG0_ELEC_BIT 4
`define POC_CFG0_SKIP_BIT 3
`define POC_CFG0_WMASK 8'h5f
`define POC_CFG0_RESET 8'h04
`define POC_STAT_DONE_BIT 0
`define POC_STAT_TRIM_BIT 1
`define POC_STAT_CALIBRATION_INTERRUPT_ENABLE_BIT 2
`define POC_OFS_MAX 9'h0ff
`define POC_OFS_MIN 9'h101
`define POC_HI_POS 8'h00
`define POC_HI_NEG 8'hff

`endif

// >>> src/poc_avg_count.v
// poc_avg_count.v - averaging sample counter for the calibration routine
// assumes one result strobe per proximity result while counting
`timescale 1ns/100ps

module poc_avg_count #(
  parameter CNT_W = 8
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire load_i,
  input wire [2:0] exp_i,
  input wire step_i,
  output wire last_o
);
  reg [CNT_W-1:0] left_q;
  reg [CNT_W-1:0] left_d;

  always @* begin
    left_d = left_q;
    if (load_i) begin
      left_d = {{(CNT_W-1){1'b0}}, 1'b1} << exp_i;
    end else if (step_i && left_q != {CNT_W{1'b0}}) begin
      left_d = left_q - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      left_q <= {CNT_W{1'b0}};
    end else begin
      left_q <= left_d;
    end
  end

  assign last_o = step_i && (left_q == {{(CNT_W-1){1'b0}}, 1'b1});
endmodule

// >>> src/poc_calib.v
// poc_calib.v - offset calibration config register and calibration sequencer
// assumes a byte register port driven by the serial-bus front end and
// a proximity engine that delivers one result per channel on res_valid_i
`timescale 1ns/100ps
`include "poc_defs.vh"

module poc_calib #(
  parameter NCH = 4,
  parameter CNT_W = 8
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire reg_wr_i,
  input wire [`POC_ADDR_W-1:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  input wire res_valid_i,
  input wire [1:0] res_chan_i,
  input wire res_zero_i,
  input wire res_high_i,
  input wire search_done_i,
  output reg search_run_o,
  output reg avg_run_o,
  output reg emitter_en_o,
  output reg [8:0] cur_offset_o,
  output wire calibration_interrupt_o
);
  // ==========================================================
  // state
  localparam ST_IDLE = 3'b001;
  localparam ST_SRCH = 3'b010;
  localparam ST_AVG = 3'b100;

  reg [2:0] st_q;
  reg [7:0] cfg_q;
  reg start_q;
  reg done_q;
  reg trim_q;
  reg calibration_interrupt_enable_q;
  reg [8:0] offs_q [0:NCH-1];
  reg [3:0] step_q;
  wire avg_last;
  wire cfg_wr;
  wire cal_wr;
  wire stat_wr;
  wire zero_hit;

  function [8:0] sat_dec;
    input [8:0] v;
    begin
      sat_dec = (v == `POC_OFS_MIN) ? v : v - 9'h001;
    end
  endfunction

  assign cfg_wr = reg_wr_i && reg_addr_i == `POC_OFS_CFG0;
  assign cal_wr = reg_wr_i && reg_addr_i == `POC_OFS_CALIB;
  assign stat_wr = reg_wr_i && reg_addr_i == `POC_OFS_STAT;
  // zero result seen while averaging with trim enabled
  assign zero_hit = (st_q == ST_AVG) && res_valid_i && res_zero_i &&
    cfg_q[`POC_CFG0_TRIM_BIT];
  assign calibration_interrupt_o = done_q && calibration_interrupt_enable_q;

  poc_avg_count #(.CNT_W(CNT_W)) u_cnt (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(st_q != ST_AVG),
    .exp_i(cfg_q[2:0]),
    .step_i((st_q == ST_AVG) && res_valid_i),
    .last_o(avg_last)
  );

  // ==========================================================
  // registers and sequencer
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_q <= `POC_CFG0_RESET;
      st_q <= ST_IDLE;
      start_q <= 1'b0;
      done_q <= 1'b0;
      trim_q <= 1'b0;
      calibration_interrupt_enable_q <= 1'b0;
      step_q <= 4'h8;
    end else begin
      if (cfg_wr) begin
        cfg_q <= reg_wdata_i & `POC_CFG0_WMASK;
      end
      if (stat_wr) begin
        calibration_interrupt_enable_q <= reg_wdata_i[`POC_STAT_CALIBRATION_INTERRUPT_ENABLE_BIT];
      end
      // hardware set wins over write-one clear
      if (zero_hit) begin
        trim_q <= 1'b1;
      end else if (stat_wr && reg_wdata_i[`POC_STAT_TRIM_BIT]) begin
        trim_q <= 1'b0;
      end
      case (st_q)
        ST_IDLE: begin
          if (cal_wr && reg_wdata_i[0]) begin
            start_q <= 1'b1;
            done_q <= 1'b0;
            step_q <= 4'h8;
            // bypass search; zero count skips averaging
            if (!cfg_q[`POC_CFG0_SKIP_BIT]) begin
              st_q <= ST_SRCH;
            end else if (cfg_q[2:0] != 3'd0) begin
              st_q <= ST_AVG;
            end else begin
              start_q <= 1'b0;
              done_q <= 1'b1;
            end
          end else if (stat_wr && reg_wdata_i[`POC_STAT_DONE_BIT]) begin
            done_q <= 1'b0;
          end
        end
        ST_SRCH: begin
          if (res_valid_i && step_q != 4'h0) begin
            step_q <= step_q - 4'h1;
          end
          if (search_done_i) begin
            st_q <= (cfg_q[2:0] != 3'd0) ? ST_AVG : ST_IDLE;
            if (cfg_q[2:0] == 3'd0) begin
              start_q <= 1'b0;
              done_q <= 1'b1;
            end
          end
        end
        ST_AVG: begin
          // averaging not restarted after a trim
          if (avg_last) begin
            st_q <= ST_IDLE;
            start_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
      if (st_q != ST_IDLE && cal_wr && !reg_wdata_i[0]) begin
        st_q <= ST_IDLE;
        start_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // per-channel offsets
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      wire lo_wr = reg_wr_i &&
        reg_addr_i == `POC_OFS_OFFS_BASE + 2 * g;
      wire hi_wr = reg_wr_i &&
        reg_addr_i == `POC_OFS_OFFS_BASE + 2 * g + 1;
      wire hit = res_valid_i && res_chan_i == g;
      always @(posedge clk_i) begin
        if (sys_rst_i) begin
          offs_q[g] <= 9'h000;
        end else if (zero_hit && res_chan_i == g) begin
          offs_q[g] <= sat_dec(offs_q[g]);
        end else if (st_q == ST_SRCH && hit && step_q != 4'h0) begin
          // binary search: add halving steps on a high result only, none on a low one
          if (res_high_i) begin
            offs_q[g] <= (offs_q[g][8] || offs_q[g] + (9'h1 << (step_q - 4'h1))
              <= `POC_OFS_MAX) ? offs_q[g] + (9'h1 << (step_q - 4'h1))
              : `POC_OFS_MAX;
          end
        end else if (lo_wr) begin
          offs_q[g] <= {offs_q[g][8], reg_wdata_i};
        end else if (hi_wr) begin
          // only 00 or ff accepted as sign
          if (reg_wdata_i == `POC_HI_NEG) begin
            offs_q[g] <= {1'b1, offs_q[g][7:0]};
          end else if (reg_wdata_i == `POC_HI_POS) begin
            offs_q[g] <= {1'b0, offs_q[g][7:0]};
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // outputs and read mux
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      search_run_o <= 1'b0;
      avg_run_o <= 1'b0;
      emitter_en_o <= 1'b0;
      cur_offset_o <= 9'h000;
    end else begin
      search_run_o <= st_q == ST_SRCH;
      avg_run_o <= st_q == ST_AVG;
      emitter_en_o <= st_q != ST_IDLE && !cfg_q[`POC_CFG0_ELEC_BIT];
      cur_offset_o <= offs_q[res_chan_i];
    end
  end

  always @* begin
    reg_rdata_o = 8'h00;
    if (reg_addr_i == `POC_OFS_CFG0) begin
      reg_rdata_o = cfg_q;
    end else if (reg_addr_i == `POC_OFS_CALIB) begin
      reg_rdata_o = {7'h00, start_q};
    end else if (reg_addr_i == `POC_OFS_STAT) begin
      reg_rdata_o = {5'h00, calibration_interrupt_enable_q, trim_q, done_q};
    end else if (reg_addr_i[7:3] == `POC_OFS_OFFS_BASE >> 3) begin
      if (reg_addr_i[0]) begin
        reg_rdata_o = offs_q[reg_addr_i[2:1]][8] ? `POC_HI_NEG : `POC_HI_POS;
      end else begin
        reg_rdata_o = offs_q[reg_addr_i[2:1]][7:0];
      end
    end
  end
endmodule

// >>> dv/poc_calib_sva.sv
// poc_calib_sva.sv - port checker for poc_calib
// assumes a config shadow rebuilt from the byte write port
`timescale 1ns/100ps
module poc_calib_sva (
  input wire clk_i,
  input wire sys_rst_i,
  input wire reg_wr_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire res_valid_i,
  input wire res_zero_i,
  input wire search_run_o,
  input wire avg_run_o,
  input wire emitter_en_o,
  input wire [8:0] cur_offset_o,
  input wire calibration_interrupt_o
);
  // ====
  // shadow of the config register
  reg [7:0] cfg_q;
  wire run_w = search_run_o | avg_run_o;
  wire start_w = reg_wr_i && reg_addr_i == 8'hd7;
  always @(posedge clk_i) begin
    if (sys_rst_i)
      cfg_q <= 8'h04;
    else if (reg_wr_i && reg_addr_i == 8'hd8)
      cfg_q <= reg_wdata_i & 8'h5f;
  end
  // ====
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // skip plus zero count has no phase to run
  sequence s_go;
    start_w && reg_wdata_i[0] && !run_w && !(cfg_q[3] && cfg_q[2:0] == 0);
  endsequence
  property p_start; s_go |-> ##[1:3] run_w; endproperty
  property p_stop; start_w && !reg_wdata_i[0] |-> ##[1:3] !run_w; endproperty
  property p_cfg; reg_addr_i == 8'hd8 |-> reg_rdata_o == cfg_q; endproperty
  property p_elec;
    run_w && $past(run_w) && cfg_q[4] |-> !emitter_en_o;
  endproperty
  property p_opt;
    avg_run_o && $past(avg_run_o) && !cfg_q[4] |-> emitter_en_o;
  endproperty
  property p_skip; cfg_q[3] |-> !$rose(search_run_o); endproperty
  property p_range; cur_offset_o != 9'h100; endproperty
  property p_irq;
    reg_addr_i == 8'hdb |->
      calibration_interrupt_o == (reg_rdata_o[0] & reg_rdata_o[2]);
  endproperty
  property p_cont;
    avg_run_o && res_valid_i && res_zero_i |=> !search_run_o;
  endproperty
  a_start: assert property (p_start) else $error("start lost");
  a_stop: assert property (p_stop) else $error("stop lost");
  a_cfg: assert property (p_cfg) else $error("cfg readback");
  a_elec: assert property (p_elec) else $error("emitter on");
  a_opt: assert property (p_opt) else $error("emitter off");
  a_skip: assert property (p_skip) else $error("search ran");
  a_range: assert property (p_range) else $error("offset -256");
  a_irq: assert property (p_irq) else $error("irq level");
  a_cont: assert property (p_cont) else $error("avg restart");
endmodule
bind poc_calib poc_calib_sva u_sva (.clk_i, .sys_rst_i, .reg_wr_i,
  .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .res_valid_i, .res_zero_i,
  .search_run_o, .avg_run_o, .emitter_en_o, .cur_offset_o,
  .calibration_interrupt_o);

// >>> dv/poc_prox_model.sv
// poc_prox_model.sv - proximity engine stand-in feeding results
// assumes run levels from poc_calib, gap and zero set by the bench
`timescale 1ns/100ps
module poc_prox_model (
  input wire clk_i,
  input wire sys_rst_i,
  input wire run_i,
  input wire search_i,
  input wire [3:0] gap_i,
  input wire zero_i,
  output reg res_valid_o,
  output reg [1:0] res_chan_o,
  output reg res_zero_o,
  output reg res_high_o,
  output reg search_done_o
);
  reg [3:0] wait_q;
  reg [3:0] step_q;
  always @(posedge clk_i) begin
    res_valid_o <= 1'b0;
    search_done_o <= 1'b0;
    // flags toggle between results so stale values never look valid
    res_zero_o <= ~res_zero_o;
    res_high_o <= ~res_high_o;
    if (sys_rst_i || !run_i) begin
      wait_q <= 4'h0;
      step_q <= 4'h0;
      res_chan_o <= 2'h3;
      res_zero_o <= 1'b0;
      res_high_o <= 1'b0;
    end else if (wait_q != gap_i) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      wait_q <= 4'h0;
      res_valid_o <= 1'b1;
      res_chan_o <= res_chan_o + 2'h1;
      res_zero_o <= zero_i & !search_i;
      res_high_o <= step_q[0];
      step_q <= step_q + 4'h1;
      search_done_o <= search_i && step_q == 4'h7;
    end
  end
endmodule

// >>> dv/tb.sv
// tb.sv - self-checking bench for poc_calib
// assumes poc_prox_model as the result source, byte register port
`timescale 1ns/100ps
module tb;
  reg clk_i = 0;
  reg sys_rst_i = 1;
  reg reg_wr_i = 0;
  reg [7:0] reg_addr_i = 8'h00;
  reg [7:0] reg_wdata_i = 8'h00;
  reg [3:0] gap = 4'h0;
  reg zero = 0;
  reg vld_q = 0;
  wire [7:0] reg_rdata_o;
  wire res_valid_i, res_zero_i, res_high_i, search_done_i;
  wire [1:0] res_chan_i;
  wire search_run_o, avg_run_o, emitter_en_o, calibration_interrupt_o;
  wire [8:0] cur_offset_o;
  integer n_mismatch = 0, comparisons = 0, n_avg, n_srch, n_emit, v, i;
  poc_calib u_poc_calib (.clk_i, .sys_rst_i, .reg_wr_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .res_valid_i, .res_chan_i, .res_zero_i,
    .res_high_i, .search_done_i, .search_run_o, .avg_run_o,
    .emitter_en_o, .cur_offset_o, .calibration_interrupt_o);
  poc_prox_model u_poc_prox_model (.clk_i, .sys_rst_i,
    .run_i(search_run_o | avg_run_o), .search_i(search_run_o),
    .gap_i(gap), .zero_i(zero), .res_valid_o(res_valid_i),
    .res_chan_o(res_chan_i), .res_zero_o(res_zero_i),
    .res_high_o(res_high_i), .search_done_o(search_done_i));
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    vld_q <= res_valid_i;
    // phase level lags the state by one edge, so pair it with last result
    if (avg_run_o && vld_q) n_avg <= n_avg + 1;
    if (search_run_o) n_srch <= n_srch + 1;
    if (search_run_o && emitter_en_o) n_emit <= n_emit + 1;
  end
  // ====
  // shared tasks
  task chk(input [8:0] got, input [8:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(negedge clk_i);
    reg_wr_i = 1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge clk_i);
    reg_wr_i = 0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(negedge clk_i);
    reg_addr_i = a;
    #1 chk({1'b0, reg_rdata_o}, {1'b0, e});
  endtask
  // bounded wait for done, irq checked, then done cleared
  task run_cal(input [7:0] cfg);
    n_avg = 0;
    n_srch = 0;
    n_emit = 0;
    wr(8'hd8, cfg);
    wr(8'hd7, 8'h01);
    reg_addr_i = 8'hdb;
    // let the read mux settle on the new address before polling
    @(negedge clk_i);
    for (i = 0; i < 2000 && reg_rdata_o[0] !== 1'b1; i = i + 1)
      @(negedge clk_i);
    chk(calibration_interrupt_o, 1);
    wr(8'hdb, 8'h05);
  endtask
  task final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    final_report;
  end
  // ====
  // scenarios
  initial begin
    repeat (8) @(negedge clk_i);
    sys_rst_i = 0;
    rd(8'hd8, 8'h04);
    wr(8'hd8, 8'hff);
    rd(8'hd8, 8'h5f);
    wr(8'hdb, 8'h04);
    for (v = 0; v < 8; v = v + 1) begin
      gap = v[3:0] & 4'h1;
      run_cal(8'h08 | v[7:0]);
      chk(n_avg[8:0], v == 0 ? 9'h000 : 9'h001 << v);
      chk(n_srch[8:0], 0);
    end
    run_cal(8'h11);
    chk(n_srch > 0, 1);
    chk(n_emit[8:0], 0);
    run_cal(8'h01);
    chk(n_emit > 0, 1);
    wr(8'hc0, 8'h01);
    wr(8'hc1, 8'hff);
    wr(8'hc2, 8'h00);
    wr(8'hc3, 8'h00);
    zero = 1;
    run_cal(8'h49);
    zero = 0;
    chk(n_avg[8:0], 2);
    rd(8'hc0, 8'h01);
    rd(8'hc1, 8'hff);
    rd(8'hc2, 8'hff);
    rd(8'hc3, 8'hff);
    rd(8'hdb, 8'h06);
    wr(8'hc6, 8'h05);
    wr(8'hc7, 8'hff);
    @(negedge clk_i);
    chk(cur_offset_o, 9'h105);
    gap = 4'h3;
    wr(8'hd8, 8'h0f);
    wr(8'hd7, 8'h01);
    repeat (20) @(negedge clk_i);
    wr(8'hd7, 8'h00);
    repeat (4) @(negedge clk_i);
    chk(avg_run_o, 0);
    rd(8'hdb, 8'h06);
    // host clears the trim flag and reruns averaging
    wr(8'hdb, 8'h06);
    run_cal(8'h49);
    chk(n_avg[8:0], 2);
    rd(8'hdb, 8'h04);
    final_report;
  end
endmodule
